// ===== verilog/ilsu_pkg.sv
// Shared types, constants and helpers for the integer load/store unit.
// Assumes big-endian byte lanes: byte offset 0 sits in the top bits of a double word.
package ilsu_pkg;
  localparam int ILSU_AW       = 32;
  localparam int ILSU_RW       = 64;
  localparam int ILSU_DW       = 64;
  localparam int ILSU_RES_LSB  = 5;
  localparam int ILSU_DISP_W   = 16;
  localparam int ILSU_GPR_W    = 5;
  localparam logic [2:0] ILSU_WIM_MASK   = 3'h6;
  localparam logic [2:0] ILSU_WIM_WT     = 3'h4;
  localparam logic [3:0] ILSU_DW_BYTES   = 4'h8;
  localparam logic [ILSU_AW-4:0] ILSU_DWA_ONE = 29'h1;

  typedef enum logic [1:0] {
    ILSU_SZ_BYTE = 2'h0,
    ILSU_SZ_HALF = 2'h1,
    ILSU_SZ_WORD = 2'h2,
    ILSU_SZ_DBL  = 2'h3
  } ilsu_size_t;

  typedef enum logic [1:0] {
    ILSU_AM_DISP  = 2'h0,
    ILSU_AM_INDEX = 2'h1,
    ILSU_AM_BASE  = 2'h2
  } ilsu_amode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SEND = 3'h2,
    ST_WAIT = 3'h4
  } ilsu_state_t;

  typedef struct packed {
    logic                   is_store;
    ilsu_size_t             size;
    logic                   algebraic;
    logic                   byte_rev;
    ilsu_amode_t            amode;
    logic                   update;
    logic                   reserve;
    logic                   cond;
    logic                   record_bit;
    logic [ILSU_GPR_W-1:0]  base_gpr;
    logic [ILSU_GPR_W-1:0]  data_gpr;
    logic [ILSU_DISP_W-1:0] disp;
    logic [ILSU_RW-1:0]     base_val;
    logic [ILSU_RW-1:0]     index_val;
    logic [ILSU_RW-1:0]     source_val;
  } ilsu_req_t;

  typedef struct packed {
    logic [ILSU_AW-4:0]  dw_addr;
    logic [7:0]          be;
    logic                we;
    logic                atomic;
    logic [ILSU_DW-1:0]  wdata;
  } ilsu_mreq_t;

  typedef struct packed {
    logic [ILSU_DW-1:0] rdata;
    logic               page_fault;
    logic [2:0]         page_storage_attrs;
  } ilsu_mrsp_t;

  typedef struct packed {
    logic [ILSU_GPR_W-1:0] gpr;
    logic [ILSU_RW-1:0]    data;
  } ilsu_wb_t;

  typedef struct packed {
    logic dsi;
    logic invalid;
    logic cond_ok;
  } ilsu_done_t;

  function automatic logic [3:0] ilsu_nbytes(input ilsu_size_t s);
    case (s)
      ILSU_SZ_BYTE: return 4'h1;
      ILSU_SZ_HALF: return 4'h2;
      ILSU_SZ_WORD: return 4'h4;
      default:      return 4'h8;
    endcase
  endfunction : ilsu_nbytes

  // Reverses the low n bytes of a right-aligned element
  function automatic logic [63:0] ilsu_brev(input logic [63:0] d, input logic [3:0] n);
    logic [63:0] r;
    r = d;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(n)) begin
        r[8*i +: 8] = d[8*(int'(n)-1-i) +: 8];
      end
    end
    return r;
  endfunction : ilsu_brev
endpackage : ilsu_pkg

// ===== verilog/ilsu_agen.sv
// Effective address and store lane placement for one load/store request.
// Purely combinational; fed straight from the dispatch request.
`timescale 1ns/1ps
module ilsu_agen
  import ilsu_pkg::*;
(
  input  wire ilsu_req_t          req_in,
  output logic [ILSU_AW-1:0]      ea_out,
  output logic [2:0]              off_out,
  output logic                    cross_out,
  output logic [15:0]             be_out,
  output logic [2*ILSU_DW-1:0]    win_out
);
  logic [ILSU_RW-1:0] sum;
  logic [3:0]         n;
  logic [3:0]         span;
  logic [63:0]        elem;
  logic [63:0]        elem_l;
  logic [7:0]         mask8;

  always_comb begin
    case (req_in.amode) // RQ6
      ILSU_AM_DISP:  sum = req_in.base_val + {{(ILSU_RW-ILSU_DISP_W){req_in.disp[ILSU_DISP_W-1]}}, req_in.disp};
      ILSU_AM_INDEX: sum = req_in.base_val + req_in.index_val;
      default:       sum = req_in.base_val;
    endcase
  end

  assign ea_out    = sum[ILSU_AW-1:0];
  assign off_out   = ea_out[2:0];
  assign n         = ilsu_nbytes(req_in.size);
  assign span      = {1'b0, off_out} + n;
  // Inside one double word the access is a single beat with lane enables
  assign cross_out = span > ILSU_DW_BYTES; // RQ2

  // Byte reversal folds into the same lane shift, so no added cycle
  assign elem   = req_in.byte_rev ? ilsu_brev(req_in.source_val, n) : req_in.source_val; // RQ10
  assign elem_l = elem << (8 * (8 - int'(n))); // RQ16
  assign mask8  = 8'hff << (8 - int'(n));
  assign win_out = {elem_l, 64'h0} >> (8 * int'(off_out));
  assign be_out  = {mask8, 8'h0} >> off_out;
endmodule : ilsu_agen

// ===== verilog/ilsu_ldfmt.sv
// Load data alignment, byte reversal and extension into register width.
// Span holds the first double word in its top half, the second below it.
`timescale 1ns/1ps
module ilsu_ldfmt
  import ilsu_pkg::*;
(
  input  wire logic [2*ILSU_DW-1:0] span_in,
  input  wire logic [2:0]           off_in,
  input  wire ilsu_size_t           size_in,
  input  wire logic                 algebraic_in,
  input  wire logic                 byte_rev_in,
  output logic [ILSU_RW-1:0]        data_out
);
  logic [2*ILSU_DW-1:0] sh;
  logic [63:0]          raw;
  logic [63:0]          elem;
  logic [3:0]           n;

  assign n    = ilsu_nbytes(size_in);
  assign sh   = span_in << (8 * int'(off_in));
  assign raw  = sh[2*ILSU_DW-1:ILSU_DW] >> (8 * (8 - int'(n))); // RQ7
  assign elem = byte_rev_in ? ilsu_brev(raw, n) : raw; // RQ10

  // Same combinational path for every variant keeps latency equal
  always_comb begin
    if (algebraic_in && size_in == ILSU_SZ_HALF) begin
      data_out = {{(ILSU_RW-16){elem[15]}}, elem[15:0]}; // RQ15 RQ9
    end else begin
      data_out = elem; // RQ15
    end
  end
endmodule : ilsu_ldfmt

// ===== verilog/ilsu_core.sv
// Integer load/store unit: one request at a time from dispatch, one or two
// double-word beats to the data memory side, register results back.
// Assumes memory answers each beat once, holds off on translation reloads,
// and suppresses an atomic write when it reports a write-through page.
//
// Contract
// (RQ1) Issue in order; accesses may reorder otherwise
// (RQ2) Misaligned within double word takes one beat
// (RQ3) Only one misaligned access outstanding
// (RQ4) Second-page fault restarts the whole access
// (RQ5) Translation reloads never restart the access
// (RQ6) Address: base+disp, base+index, or base
// (RQ7) Load element into destination register
// (RQ8) Load update writes address; bad base invalid
// (RQ9) Algebraic half loads take normal latency
// (RQ10) Byte-reversed forms take normal latency
// (RQ11) All multiple/move-assist encodings equally fast
// (RQ12) Reservation covers aligned 32-byte section
// (RQ13) Atomic to write-through page raises storage fault
// (RQ14) Byte/half/word zero and half algebraic loads
// (RQ15) Sign-extend algebraic, zero-fill the rest
// (RQ16) Store source element at effective address
// (RQ17) Store original source before base update
// (RQ18) Store update base zero or record bit invalid
// (RQ19) Byte, half, word stores in all forms
// (RQ20) Sync after icache invalidate waits for it
`timescale 1ns/1ps
module ilsu_core
  import ilsu_pkg::*;
#(
  parameter int RES_LSB = ILSU_RES_LSB
)(
  input  wire logic                      REF_CLK_IN,
  input  wire logic                      ARST_N_IN,
  input  wire logic                      REQ_VALID_IN,
  input  wire ilsu_req_t                 REQ_IN,
  output logic                           REQ_READY_OUT,
  output logic                           MEM_REQ_VALID_OUT,
  output ilsu_mreq_t                     MEM_REQ_OUT,
  input  wire logic                      MEM_REQ_READY_IN,
  input  wire logic                      MEM_RSP_VALID_IN,
  input  wire ilsu_mrsp_t                MEM_RSP_IN,
  output logic                           WB_VALID_OUT,
  output ilsu_wb_t                       WB_OUT,
  output logic                           UPD_VALID_OUT,
  output ilsu_wb_t                       UPD_OUT,
  output logic                           DONE_VALID_OUT,
  output ilsu_done_t                     DONE_OUT,
  output logic                           RES_VALID_OUT,
  output logic [ILSU_AW-RES_LSB-1:0]     RES_GRANULE_OUT,
  input  wire logic                      SYNC_REQ_IN,
  input  wire logic                      ICBI_PEND_IN,
  output logic                           SYNC_DONE_OUT
);
  generate
    if (RES_LSB < 3 || RES_LSB >= ILSU_AW) begin : g_bad_res
      $error("RES_LSB out of range");
    end
  endgenerate

  ilsu_state_t           state;
  ilsu_req_t             op;
  logic [ILSU_AW-1:0]    op_ea;
  logic [2:0]            op_off;
  logic                  op_cross;
  logic [15:0]           op_be;
  logic [2*ILSU_DW-1:0]  op_win;
  logic                  second;
  logic [ILSU_DW-1:0]    span_hi;

  logic [ILSU_AW-1:0]    ag_ea;
  logic [2:0]            ag_off;
  logic                  ag_cross;
  logic [15:0]           ag_be;
  logic [2*ILSU_DW-1:0]  ag_win;
  logic [ILSU_RW-1:0]    ld_data;
  logic [2*ILSU_DW-1:0]  ld_span;

  logic accept;
  logic inv_form;
  logic skip_cond;
  logic rsp;
  logic wim_bad;
  logic bad;
  logic final_beat;
  logic res_hit;

  ilsu_agen u_agen (
    .req_in    (REQ_IN),
    .ea_out    (ag_ea),
    .off_out   (ag_off),
    .cross_out (ag_cross),
    .be_out    (ag_be),
    .win_out   (ag_win)
  );

  assign ld_span = op_cross ? {span_hi, MEM_RSP_IN.rdata} : {MEM_RSP_IN.rdata, 64'h0};

  ilsu_ldfmt u_ldfmt (
    .span_in      (ld_span),
    .off_in       (op_off),
    .size_in      (op.size),
    .algebraic_in (op.algebraic),
    .byte_rev_in  (op.byte_rev),
    .data_out     (ld_data)
  );

  // A pending sync holds off new work so ordering stays strict
  assign REQ_READY_OUT = (state == ST_IDLE) && !SYNC_REQ_IN; // RQ1 RQ3
  assign accept        = REQ_VALID_IN && REQ_READY_OUT;
  assign SYNC_DONE_OUT = SYNC_REQ_IN && (state == ST_IDLE) && !ICBI_PEND_IN; // RQ20

  assign inv_form = (REQ_IN.update && REQ_IN.base_gpr == '0) // RQ8 RQ18
                  || (!REQ_IN.is_store && REQ_IN.update && REQ_IN.base_gpr == REQ_IN.data_gpr) // RQ8
                  || (REQ_IN.is_store && REQ_IN.record_bit); // RQ18
  assign res_hit   = RES_VALID_OUT && (RES_GRANULE_OUT == ag_ea[ILSU_AW-1:RES_LSB]); // RQ12
  // A conditional store without a live reservation never reaches memory
  assign skip_cond = REQ_IN.is_store && REQ_IN.cond && !res_hit;

  assign rsp        = (state == ST_WAIT) && MEM_RSP_VALID_IN;
  assign wim_bad    = (op.reserve || op.cond)
                    && ((MEM_RSP_IN.page_storage_attrs & ILSU_WIM_MASK) == ILSU_WIM_WT); // RQ13
  assign bad        = MEM_RSP_IN.page_fault || wim_bad;
  assign final_beat = rsp && (bad || !op_cross || second);
  assign MEM_REQ_VALID_OUT = (state == ST_SEND);

  // Sequencer; waits on memory for any time, so table reloads stay invisible
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state  <= ST_IDLE;
      second <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept && !inv_form && !skip_cond) begin
            // Every encoding takes this same path, so none is faster
            state  <= ST_SEND; // RQ11
            second <= 1'b0;
          end
        end
        ST_SEND: begin
          if (MEM_REQ_READY_IN) begin
            state <= ST_WAIT; // RQ5
          end
        end
        ST_WAIT: begin
          if (rsp) begin
            if (bad) begin
              // Abandon; a reissue repeats the first portion too
              state  <= ST_IDLE; // RQ4
              second <= 1'b0;
            end else if (op_cross && !second) begin
              state  <= ST_SEND; // RQ2
              second <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state  <= ST_IDLE;
          second <= 1'b0;
        end
      endcase
    end
  end

  // Operation capture; source value is the pre-update copy
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      op       <= '0;
      op_ea    <= '0;
      op_off   <= 3'h0;
      op_cross <= 1'b0;
      op_be    <= 16'h0;
      op_win   <= '0;
    end else if (accept) begin
      op       <= REQ_IN;
      op_ea    <= ag_ea;
      op_off   <= ag_off;
      op_cross <= ag_cross;
      op_be    <= ag_be;
      op_win   <= ag_win; // RQ17
    end
  end

  // Memory beat, registered so the request holds steady while stalled
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      MEM_REQ_OUT <= '0;
    end else if (state == ST_IDLE && accept) begin
      MEM_REQ_OUT.dw_addr <= ag_ea[ILSU_AW-1:3];
      MEM_REQ_OUT.be      <= ag_be[15:8];
      MEM_REQ_OUT.we      <= REQ_IN.is_store; // RQ16 RQ19
      MEM_REQ_OUT.atomic  <= REQ_IN.reserve || REQ_IN.cond;
      MEM_REQ_OUT.wdata   <= ag_win[2*ILSU_DW-1:ILSU_DW];
    end else if (rsp && !bad && op_cross && !second) begin
      MEM_REQ_OUT.dw_addr <= MEM_REQ_OUT.dw_addr + ILSU_DWA_ONE; // RQ2
      MEM_REQ_OUT.be      <= op_be[7:0];
      MEM_REQ_OUT.wdata   <= op_win[ILSU_DW-1:0];
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      span_hi <= '0;
    end else if (rsp && !second) begin
      span_hi <= MEM_RSP_IN.rdata;
    end
  end

  // Results: one edge after the last beat for every load variant
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      WB_VALID_OUT   <= 1'b0;
      WB_OUT         <= '0;
      UPD_VALID_OUT  <= 1'b0;
      UPD_OUT        <= '0;
      DONE_VALID_OUT <= 1'b0;
      DONE_OUT       <= '0;
    end else begin
      WB_VALID_OUT   <= 1'b0;
      UPD_VALID_OUT  <= 1'b0;
      DONE_VALID_OUT <= 1'b0;
      if (accept && (inv_form || skip_cond)) begin
        DONE_VALID_OUT   <= 1'b1;
        DONE_OUT.dsi     <= 1'b0;
        DONE_OUT.invalid <= inv_form; // RQ8 RQ18
        DONE_OUT.cond_ok <= 1'b0;
      end else if (final_beat) begin
        DONE_VALID_OUT   <= 1'b1;
        DONE_OUT.dsi     <= bad; // RQ4 RQ13
        DONE_OUT.invalid <= 1'b0;
        DONE_OUT.cond_ok <= op.cond && !bad;
        if (!bad && !op.is_store) begin
          WB_VALID_OUT <= 1'b1; // RQ7 RQ9 RQ14
          WB_OUT.gpr   <= op.data_gpr;
          WB_OUT.data  <= ld_data;
        end
        if (!bad && op.update) begin
          // Base update only after the store beat has been answered
          UPD_VALID_OUT <= 1'b1; // RQ8 RQ17
          UPD_OUT.gpr   <= op.base_gpr;
          UPD_OUT.data  <= {{(ILSU_RW-ILSU_AW){1'b0}}, op_ea};
        end
      end
    end
  end

  // Reservation granule
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RES_VALID_OUT   <= 1'b0;
      RES_GRANULE_OUT <= '0;
    end else if (accept && skip_cond) begin
      RES_VALID_OUT <= 1'b0;
    end else if (final_beat && !bad && op.reserve && !op.is_store) begin
      RES_VALID_OUT   <= 1'b1;
      RES_GRANULE_OUT <= op_ea[ILSU_AW-1:RES_LSB]; // RQ12
    end else if (final_beat && op.cond) begin
      RES_VALID_OUT <= 1'b0;
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  chk_one_outstanding: // RQ3
  assert property ((state != ST_IDLE) |-> !REQ_READY_OUT)
    else $error("new request taken while an access is in flight");

  chk_in_order: // RQ1
  assert property (MEM_REQ_VALID_OUT |-> !REQ_READY_OUT ##1 (MEM_REQ_VALID_OUT || state == ST_WAIT))
    else $error("request taken while a beat is pending");

  chk_single_beat: // RQ2
  assert property ((state == ST_SEND && second) |-> op_cross)
    else $error("second beat for an access inside one double word");

  chk_fault_restart: // RQ4
  assert property (rsp && MEM_RSP_IN.page_fault |=> DONE_VALID_OUT && DONE_OUT.dsi
                   && !WB_VALID_OUT && !UPD_VALID_OUT && state == ST_IDLE && !second)
    else $error("faulting access not abandoned");

  chk_invalid_form: // RQ8 RQ18
  assert property (accept && inv_form |=> DONE_VALID_OUT && DONE_OUT.invalid
                   && !MEM_REQ_VALID_OUT && state == ST_IDLE)
    else $error("invalid form reached memory or was not flagged");

  chk_update_ea: // RQ8
  assert property (UPD_VALID_OUT |-> UPD_OUT.data[ILSU_AW-1:0] == op_ea && UPD_OUT.gpr == op.base_gpr)
    else $error("update register or value wrong");

  chk_load_latency: // RQ9
  assert property (final_beat && !bad && !op.is_store |=> WB_VALID_OUT && WB_OUT.gpr == op.data_gpr)
    else $error("load result not one cycle after last beat");

  chk_res_granule: // RQ12
  assert property (final_beat && !bad && op.reserve && !op.is_store
                   |=> RES_VALID_OUT && RES_GRANULE_OUT == op_ea[ILSU_AW-1:RES_LSB])
    else $error("reservation granule wrong");

  chk_atomic_wim: // RQ13
  assert property (rsp && wim_bad |=> DONE_VALID_OUT && DONE_OUT.dsi
                   && ($past(op.cond) ? !RES_VALID_OUT : $stable(RES_VALID_OUT))
                   && $stable(RES_GRANULE_OUT))
    else $error("atomic to write-through page not faulted");

  chk_sync_icbi: // RQ20
  assert property (ICBI_PEND_IN |-> !SYNC_DONE_OUT)
    else $error("sync completed with invalidation pending");

  cov_cross: cover property (state == ST_SEND && second ##[1:20] DONE_VALID_OUT);
  cov_sync: cover property (SYNC_DONE_OUT);
  cov_stcx_ok: cover property (DONE_VALID_OUT && DONE_OUT.cond_ok);
  cov_fault: cover property (DONE_VALID_OUT && DONE_OUT.dsi);
endmodule : ilsu_core

// ===== testbench/ilsu_mem_model.sv
// Behavioural data memory behind the load/store unit: 16 double words.
// Assumes one beat outstanding; each beat is answered after lat_in cycles.
`timescale 1ns/1ps
module ilsu_mem_model
  import ilsu_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        req_valid_in,
  input  wire ilsu_mreq_t  req_in,
  output logic             req_ready_out,
  output logic             rsp_valid_out,
  output ilsu_mrsp_t       rsp_out,
  input  wire logic [3:0]  lat_in,
  input  wire logic        fault_en_in,
  input  wire logic [28:0] fault_dw_in,
  input  wire logic [2:0]  attrs_in
);
  logic [63:0] mem [16];
  logic        busy;
  logic        fire;
  logic        flt;
  logic [3:0]  cnt;
  ilsu_mreq_t  held;

  // Byte k of word i holds {i, 0, k}
  initial begin
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 8; k++) begin
        mem[i][63-8*k -: 8] = {i[3:0], 1'b0, k[2:0]};
      end
    end
  end

  assign req_ready_out = !busy;
  assign fire          = busy && (cnt <= 4'h1);

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy          <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_out       <= '0;
    end else begin
      rsp_valid_out <= fire;
      // Data is never left standing between answers
      if (!fire) begin
        rsp_out.rdata <= ~rsp_out.rdata;
      end
      if (req_valid_in && !busy) begin
        busy <= 1'b1;
        held <= req_in;
        cnt  <= lat_in;
        flt  <= fault_en_in && (req_in.dw_addr == fault_dw_in);
      end else if (busy && !fire) begin
        cnt <= cnt - 4'h1;
      end else if (fire) begin
        busy                       <= 1'b0;
        rsp_out.rdata              <= mem[held.dw_addr[3:0]];
        rsp_out.page_fault         <= flt;
        rsp_out.page_storage_attrs <= attrs_in;
        // Faulting beats and write-through atomics never land
        if (held.we && !flt && !(held.atomic && ((attrs_in & ILSU_WIM_MASK) == ILSU_WIM_WT))) begin
          for (int b = 0; b < 8; b++) begin
            if (held.be[b]) begin
              mem[held.dw_addr[3:0]][8*b +: 8] <= held.wdata[8*b +: 8];
            end
          end
        end
      end
    end
  end
endmodule : ilsu_mem_model

// ===== testbench/testbench.sv
// Self-checking bench for the load/store unit with a behavioural memory.
// Assumes one request at a time; every result arrives with the done pulse.
`timescale 1ns/1ps
module testbench;
  import ilsu_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0;
  logic        sync_req = 1'b0, icbi = 1'b0, flt_en = 1'b0;
  logic [3:0]  lat = 4'h1;
  logic [28:0] flt_dw = '0;
  logic [2:0]  attrs = 3'h0;
  ilsu_req_t   q = '0;
  logic        mreq_valid, mreq_ready, mrsp_valid, req_ready, sync_done;
  logic        wb_valid, upd_valid, done_valid, res_valid, r_wbv, r_updv, r_rdy;
  ilsu_mreq_t  mreq;
  ilsu_mrsp_t  mrsp;
  ilsu_wb_t    wb, upd, r_wb, r_upd;
  ilsu_done_t  done, r_done;
  logic [26:0] granule;
  int          failures = 0, num_checks = 0, beats = 0, r_lat;

  always #50 clk = ~clk;
  always @(posedge clk) if (mreq_valid && mreq_ready) beats++;

  ilsu_core ilsu_core_i (
    .REF_CLK_IN(clk), .ARST_N_IN(arst_n), .REQ_VALID_IN(req_valid), .REQ_IN(q),
    .REQ_READY_OUT(req_ready), .MEM_REQ_VALID_OUT(mreq_valid), .MEM_REQ_OUT(mreq),
    .MEM_REQ_READY_IN(mreq_ready), .MEM_RSP_VALID_IN(mrsp_valid), .MEM_RSP_IN(mrsp),
    .WB_VALID_OUT(wb_valid), .WB_OUT(wb), .UPD_VALID_OUT(upd_valid), .UPD_OUT(upd),
    .DONE_VALID_OUT(done_valid), .DONE_OUT(done), .RES_VALID_OUT(res_valid),
    .RES_GRANULE_OUT(granule), .SYNC_REQ_IN(sync_req), .ICBI_PEND_IN(icbi), .SYNC_DONE_OUT(sync_done));
  ilsu_mem_model ilsu_mem_model_i (
    .clk_in(clk), .arst_n_in(arst_n), .req_valid_in(mreq_valid), .req_in(mreq),
    .req_ready_out(mreq_ready), .rsp_valid_out(mrsp_valid), .rsp_out(mrsp), .lat_in(lat),
    .fault_en_in(flt_en), .fault_dw_in(flt_dw), .attrs_in(attrs));

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic fail(input string m);
    failures++;
    $display("[FAIL] t=%0t %s", $time, m);
  endtask : fail

  task automatic chk_bit(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) fail(m);
  endtask : chk_bit

  task automatic chk_val(input logic [63:0] g, input logic [63:0] e, input string m);
    num_checks++;
    if (g !== e) fail(m);
  endtask : chk_val

  task automatic chk_cnt(input int g, input int e, input string m);
    num_checks++;
    if (g != e) fail(m);
  endtask : chk_cnt

  function automatic ilsu_req_t mk(input int s, input logic [63:0] b, input logic [15:0] d);
    ilsu_req_t r;
    r = '0;
    r.size = ilsu_size_t'(s);
    r.base_gpr = 5'h3;
    r.data_gpr = 5'h4;
    r.base_val = b;
    r.disp = d;
    return r;
  endfunction : mk

  // Big-endian element from the model's fill pattern
  function automatic logic [63:0] ev(input logic [31:0] a, input int n, input logic alg, input logic rev);
    logic [63:0] v;
    logic [31:0] p;
    v = '0;
    for (int j = 0; j < n; j++) begin
      p = a + j;
      if (rev) v[8*j +: 8] = {p[6:3], 1'b0, p[2:0]};
      else v = {v[55:0], p[6:3], 1'b0, p[2:0]};
    end
    if (alg) v = {{48{v[15]}}, v[15:0]};
    return v;
  endfunction : ev

  // Offers q until taken, then waits for the done pulse
  task automatic op();
    int n;
    n = 0;
    req_valid = 1'b1;
    while (!req_ready && n < 40) begin
      tick();
      n++;
    end
    beats = 0;
    tick();
    req_valid = 1'b0;
    r_rdy = 1'b0;
    r_lat = 0;
    while (done_valid !== 1'b1 && r_lat < 40) begin
      r_rdy |= req_ready;
      tick();
      r_lat++;
    end
    if (n == 40 || r_lat == 40) begin
      fail("handshake timeout");
      test_done();
    end
    r_done = done;
    r_wbv = wb_valid;
    r_wb = wb;
    r_updv = upd_valid;
    r_upd = upd;
  endtask : op

  task automatic t_loads();
    logic [31:0] t;
    for (int v = 0; v < 3; v++) begin
      for (int s = 0; s < 4; s++) begin
        for (int m = 0; m < 3; m++) begin
          if ((v == 1 && s != 1) || (v == 2 && (s == 0 || s == 3))) continue;
          t = 32'h140 + 8 * s + (s == 0 ? 3 : s == 1 ? 5 : s == 2 ? 4 : 0);
          q = mk(s, (m == 2) ? 64'(t) : 64'h100, 16'(t - 32'h100));
          q.index_val = 64'(t - 32'h100);
          q.amode = ilsu_amode_t'(m);
          q.algebraic = (v == 1);
          q.byte_rev = (v == 2);
          op();
          chk_val(r_wb.data, ev(t, 1 << s, v == 1, v == 2), "load data");
          chk_val(64'(r_wb.gpr), 64'h4, "load dest");
          chk_bit(r_wbv, 1'b1, "load result");
          chk_cnt(r_lat, 3, "load latency");
          chk_cnt(beats, 1, "one beat");
        end
      end
    end
    $display("test loads done");
  endtask : t_loads

  task automatic t_upd();
    q = mk(1, 64'h100, 16'h52);
    q.algebraic = 1'b1;
    q.update = 1'b1;
    op();
    chk_bit(r_updv & !r_done.invalid, 1'b1, "update pulse");
    chk_val(r_upd.data, 64'h152, "update value");
    chk_val(64'(r_upd.gpr), 64'h3, "update reg");
    chk_val(r_wb.data, ev(32'h152, 2, 1'b1, 1'b0), "update data");
    for (int k = 0; k < 2; k++) begin
      q.base_gpr = (k == 0) ? 5'h0 : 5'h4;
      op();
      chk_bit(r_done.invalid, 1'b1, "invalid load");
      chk_cnt(beats, 0, "invalid access");
      chk_bit(r_wbv | r_updv, 1'b0, "invalid writeback");
    end
    $display("test update loads done");
  endtask : t_upd

  task automatic t_stores();
    logic [31:0] t;
    logic [63:0] w;
    for (int s = 0; s < 4; s++) begin
      t = (s == 3) ? 32'h128 : 32'h111 + 9 * s;
      // Source and base are one register: stored value is its old contents
      q = mk(s, 64'h0123456789ab0100, 16'(t - 32'h100));
      q.is_store = 1'b1;
      q.update = (s != 3);
      q.amode = (s == 3) ? ILSU_AM_INDEX : ILSU_AM_DISP;
      q.index_val = 64'(t - 32'h100);
      q.data_gpr = 5'h3;
      q.source_val = q.base_val;
      w = ilsu_mem_model_i.mem[t[6:3]];
      for (int j = 0; j < (1 << s); j++) w[63-8*(t[2:0]+j) -: 8] = q.source_val[8*((1<<s)-1-j) +: 8];
      op();
      chk_val(ilsu_mem_model_i.mem[t[6:3]], w, "stored word");
      chk_cnt(beats, 1, "store beat");
      chk_val(r_updv ? r_upd.data : 64'h0, (s == 3) ? 64'h0 : 64'(32'h89ab0000 + t), "store update");
    end
    q.record_bit = 1'b1;
    op();
    chk_bit(r_done.invalid, 1'b1, "record bit store");
    chk_cnt(beats, 0, "record bit access");
    q.record_bit = 1'b0;
    q.update = 1'b1;
    q.base_gpr = 5'h0;
    op();
    chk_bit(r_done.invalid, 1'b1, "update base zero");
    $display("test stores done");
  endtask : t_stores

  task automatic t_cross();
    q = mk(2, 64'h13e, 16'h0);
    q.amode = ILSU_AM_BASE;
    flt_en = 1'b1;
    flt_dw = 29'h28;
    op();
    chk_bit(r_done.dsi & !r_wbv, 1'b1, "second page fault");
    chk_cnt(beats, 2, "both portions");
    flt_en = 1'b0;
    op();
    chk_cnt(beats, 2, "first portion repeated");
    chk_cnt(r_lat, 6, "crossing latency");
    chk_bit(r_rdy, 1'b0, "one misaligned");
    chk_val(r_wb.data, ev(32'h13e, 4, 1'b0, 1'b0), "crossing data");
    lat = 4'h4;
    q = mk(3, 64'h148, 16'h0);
    op();
    chk_bit(r_done.dsi, 1'b0, "slow beat fault");
    chk_cnt(beats, 1, "slow beat restart");
    chk_val(r_wb.data, ev(32'h148, 8, 1'b0, 1'b0), "slow data");
    lat = 4'h1;
    $display("test crossing done");
  endtask : t_cross

  task automatic t_atomic();
    for (int k = 0; k < 2; k++) begin
      q = mk(2, 64'h0, 16'h148);
      q.reserve = 1'b1;
      op();
      tick();
      chk_bit(res_valid, 1'b1, "reservation set");
      chk_val(64'(granule), 64'h148 >> 5, "granule");
      q = mk(2, 64'h0, (k == 0) ? 16'h160 : 16'h15c);
      q.is_store = 1'b1;
      q.cond = 1'b1;
      q.source_val = 64'h5a;
      op();
      tick();
      chk_bit(r_done.cond_ok, k == 1, "conditional result");
      chk_cnt(beats, k, "conditional beat");
      chk_bit(res_valid, 1'b0, "reservation used");
    end
    attrs = 3'h5;
    q = mk(2, 64'h0, 16'h148);
    q.reserve = 1'b1;
    op();
    tick();
    chk_bit(r_done.dsi, 1'b1, "write-through atomic");
    chk_bit(res_valid, 1'b0, "no reservation");
    attrs = 3'h0;
    $display("test atomic done");
  endtask : t_atomic

  task automatic t_sync();
    sync_req = 1'b1;
    icbi = 1'b1;
    tick();
    chk_bit(sync_done, 1'b0, "sync waits");
    chk_bit(req_ready, 1'b0, "dispatch held");
    icbi = 1'b0;
    tick();
    chk_bit(sync_done, 1'b1, "sync completes");
    sync_req = 1'b0;
    $display("test sync done");
  endtask : t_sync

  initial begin
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    t_loads();
    t_upd();
    t_stores();
    t_cross();
    t_atomic();
    t_sync();
    test_done();
  end
endmodule : testbench
